// *** hdl/wit_pkg.sv ***
// Constants, register map and state types of the watch interval timer
package wit_pkg;
    // ==========================================================
    // Widths
    // ==========================================================
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int DIV_W = 11;
    localparam int PRE_W = 9;
    localparam int CNT_W = 5;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [ADDR_W-1:0] MODE_ADDR = 16'hff41;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 16'hff50;
    localparam logic [ADDR_W-1:0] MASK_ADDR = 16'hff51;
    localparam logic [DATA_W-1:0] MODE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] MODE_WMASK = 8'hfb;
    localparam logic [1:0] STAT_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;

    // ==========================================================
    // Mode register fields
    // ==========================================================
    localparam int CLK_SEL_BIT = 7;
    localparam int IVL_MSB = 6;
    localparam int IVL_LSB = 4;
    localparam int FAST_BIT = 3;
    localparam int ZERO_BIT = 2;
    localparam int CNT_RUN_BIT = 1;
    localparam int PRE_RUN_BIT = 0;

    // Status and mask bits
    localparam int EV_WATCH_BIT = 0;
    localparam int EV_IVL_BIT = 1;

    // ==========================================================
    // Divide ratios as powers of two
    // ==========================================================
    localparam int DIV_FAST_LOG = 7;
    localparam int DIV_SLOW_LOG = 11;
    localparam logic [3:0] IVL_BASE_LOG = 4'h4;
    localparam logic [2:0] IVL_MAX_CODE = 3'h5;
    localparam int FEED_LOG = 5;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
        logic bit_wr;
        logic [2:0] bit_sel;
        logic bit_val;
    } wit_bus_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] mode;
        logic [DIV_W-1:0] div;
        logic [PRE_W-1:0] pre;
        logic [CNT_W-1:0] cnt;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [DATA_W-1:0] rdata;
        logic watch_p;
        logic ivl_p;
    } wit_state_t;
endpackage

// *** hdl/wit_timer.sv ***
// Watch timer with interval tap, mode register and interrupt status
// ==========================================================
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns

module wit_timer
#(
    // Widths and divider taps; widths must match the package, taps must fit the divider and prescaler, with the fast tap below the slow one
    parameter int PRE_W = wit_pkg::PRE_W,
    parameter int CNT_W = wit_pkg::CNT_W,
    parameter int DIV_W = wit_pkg::DIV_W,
    parameter int FAST_LOG = wit_pkg::DIV_FAST_LOG,
    parameter int SLOW_LOG = wit_pkg::DIV_SLOW_LOG,
    parameter int FEED_LOG = wit_pkg::FEED_LOG
)
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Register port
    input wire wit_pkg::wit_bus_req_t i_req,
    output logic [wit_pkg::DATA_W-1:0] o_rdata,
    // Interrupts
    output logic o_watch_irq,
    output logic o_interval_irq,
    output logic o_irq
);
    // ==========================================================
    // State
    // ==========================================================
    localparam int N_CODES = 2 ** (wit_pkg::IVL_MSB - wit_pkg::IVL_LSB + 1);
    localparam wit_pkg::wit_state_t S_RESET = '{mode: wit_pkg::MODE_RESET, div: '0, pre: '0,
        cnt: '0, stat: wit_pkg::STAT_RESET, mask: wit_pkg::MASK_RESET, rdata: '0,
        watch_p: 1'b0, ivl_p: 1'b0};

    wit_pkg::wit_state_t s_r;
    wit_pkg::wit_state_t s_nxt;

    logic fw_tick;
    logic pre_run;
    logic cnt_run;
    logic [wit_pkg::PRE_W-1:0] pre_inc;
    logic [N_CODES-1:0] tap_hit;
    logic [1:0] pend;
    logic pre_wrap;
    logic ivl_ev;
    logic watch_ev;
    logic [1:0] events;
    logic [1:0] w1c;

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    // The state record is sized by the package, so the widths cannot move on their own
    generate
        if (PRE_W != wit_pkg::PRE_W)
        begin : g_chk_pre
            $error("prescaler width must match the state record");
        end
        if (CNT_W != wit_pkg::CNT_W || CNT_W < 1)
        begin : g_chk_cnt
            $error("counter width must match the state record");
        end
        if (DIV_W != wit_pkg::DIV_W)
        begin : g_chk_div
            $error("divider width must match the state record");
        end
        if (SLOW_LOG < 1 || SLOW_LOG > DIV_W)
        begin : g_chk_slow
            $error("slow watch clock tap lies outside the divider");
        end
        if (FAST_LOG < 1 || FAST_LOG >= SLOW_LOG)
        begin : g_chk_fast
            $error("fast watch clock tap must lie below the slow one");
        end
        if (FEED_LOG < 1 || FEED_LOG > PRE_W)
        begin : g_chk_feed
            $error("fast feed tap lies outside the prescaler");
        end
        if (int'(wit_pkg::IVL_BASE_LOG) + int'(wit_pkg::IVL_MAX_CODE) > PRE_W)
        begin : g_chk_ivl
            $error("longest interval tap lies outside the prescaler");
        end
        if (wit_pkg::CLK_SEL_BIT >= wit_pkg::DATA_W)
        begin : g_chk_mode
            $error("mode fields must fit the data width");
        end
    endgenerate

    // ==========================================================
    // Interval taps, one per select code
    // ==========================================================
    // A fixed tap per code avoids a variable shifter on the prescaler
    for (genvar code = 0; code < N_CODES; code++)
    begin : g_tap
        if (code <= int'(wit_pkg::IVL_MAX_CODE))
        begin : g_legal
            localparam int TAP_LOG = int'(wit_pkg::IVL_BASE_LOG) + code;
            assign tap_hit[code] = (pre_inc[TAP_LOG-1:0] == '0);
        end
        else
        begin : g_banned
            // Prohibited codes never fire
            assign tap_hit[code] = 1'b0;
        end
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        s_nxt = s_r;
        pre_run = s_r.mode[wit_pkg::PRE_RUN_BIT];
        cnt_run = s_r.mode[wit_pkg::CNT_RUN_BIT];

        // Free-running main clock divider, never cleared, so the watch clock phase stays
        s_nxt.div = s_r.div + 1'b1;
        if (s_r.mode[wit_pkg::CLK_SEL_BIT])
        begin
            fw_tick = &s_r.div[SLOW_LOG-1:0];
        end
        else
        begin
            fw_tick = &s_r.div[FAST_LOG-1:0];
        end

        // Prescaler
        pre_inc = s_r.pre + 1'b1;
        pre_wrap = pre_run & fw_tick & (&s_r.pre);
        if (!pre_run)
        begin
            s_nxt.pre = '0;
        end
        else if (fw_tick)
        begin
            s_nxt.pre = pre_inc;
        end

        // Interval tap; prohibited codes never fire
        ivl_ev = pre_run & fw_tick
            & tap_hit[s_r.mode[wit_pkg::IVL_MSB:wit_pkg::IVL_LSB]];

        // 5-bit counter; prescaler is left alone when only the counter is cleared
        if (!cnt_run)
        begin
            s_nxt.cnt = '0;
        end
        else if (pre_wrap)
        begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end

        if (s_r.mode[wit_pkg::FAST_BIT])
        begin
            watch_ev = cnt_run & pre_run & fw_tick & (pre_inc[FEED_LOG-1:0] == '0);
        end
        else
        begin
            watch_ev = cnt_run & pre_wrap & (&s_r.cnt);
        end

        // One-cycle request pulses, separate per source
        s_nxt.watch_p = watch_ev;
        s_nxt.ivl_p = ivl_ev;
        events = '0;
        events[wit_pkg::EV_WATCH_BIT] = watch_ev;
        events[wit_pkg::EV_IVL_BIT] = ivl_ev;

        // Register writes
        w1c = '0;
        if (i_req.wr)
        begin
            case (i_req.addr)
                wit_pkg::MODE_ADDR:
                begin
                    s_nxt.mode = i_req.wdata & wit_pkg::MODE_WMASK;
                end
                wit_pkg::STAT_ADDR:
                begin
                    w1c = i_req.wdata[1:0];
                end
                wit_pkg::MASK_ADDR:
                begin
                    s_nxt.mask = i_req.wdata[1:0];
                end
                default:
                begin
                end
            endcase
        end
        if (i_req.bit_wr && i_req.addr == wit_pkg::MODE_ADDR
            && i_req.bit_sel != 3'(wit_pkg::ZERO_BIT))
        begin
            s_nxt.mode[i_req.bit_sel] = i_req.bit_val;
        end

        // New event beats a clear in the same cycle
        s_nxt.stat = (s_r.stat & ~w1c) | events;

        // Read data valid only in the cycle after the strobe
        s_nxt.rdata = '0;
        if (i_req.rd)
        begin
            case (i_req.addr)
                wit_pkg::MODE_ADDR:
                begin
                    s_nxt.rdata = s_r.mode;
                end
                wit_pkg::STAT_ADDR:
                begin
                    s_nxt.rdata = {6'h00, s_r.stat};
                end
                wit_pkg::MASK_ADDR:
                begin
                    s_nxt.rdata = {6'h00, s_r.mask};
                end
                default:
                begin
                    s_nxt.rdata = '0;
                end
            endcase
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            s_r <= S_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign o_rdata = s_r.rdata;
    assign o_watch_irq = s_r.watch_p;
    assign o_interval_irq = s_r.ivl_p;
    // One pending flag per event source
    for (genvar ev = 0; ev < $bits(pend); ev++)
    begin : g_pend
        assign pend[ev] = s_r.stat[ev] & s_r.mask[ev];
    end
    assign o_irq = |pend;
endmodule

// *** dv/wit_timer_props.sv ***
// Port checks for the watch interval timer
`timescale 1ns/1ns

module wit_timer_props
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Register port
    input wire wit_pkg::wit_bus_req_t i_req,
    input wire logic [wit_pkg::DATA_W-1:0] o_rdata,
    // Interrupts
    input wire logic o_watch_irq,
    input wire logic o_interval_irq,
    input wire logic o_irq
);
    logic [7:0] mode_r;
    logic [1:0] mask_r;

    // ==========================================================
    // Shadow registers
    // ==========================================================
    // Rebuilt from bus traffic only, so a stuck register in the design shows up
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            mode_r <= 8'h00;
            mask_r <= 2'h0;
        end
        else if (i_req.wr && i_req.addr == wit_pkg::MODE_ADDR)
            mode_r <= i_req.wdata & wit_pkg::MODE_WMASK;
        else if (i_req.bit_wr && i_req.addr == wit_pkg::MODE_ADDR && i_req.bit_sel != 3'h2)
            mode_r[i_req.bit_sel] <= i_req.bit_val;
        else if (i_req.wr && i_req.addr == wit_pkg::MASK_ADDR)
            mask_r <= i_req.wdata[1:0];
    end

    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    sequence s_mode_read;
        i_req.rd && i_req.addr == wit_pkg::MODE_ADDR;
    endsequence
    sequence s_pre_stopped;
        !mode_r[0] [*3];
    endsequence
    a_mode_read_back: assert property (s_mode_read |=> o_rdata == $past(mode_r))
        else $error("mode read data wrong");
    a_rdata_idle: assert property (!$past(i_req.rd) |-> o_rdata == 8'h00)
        else $error("read data outside read");
    a_ivl_single_pulse: assert property (o_interval_irq |=> !o_interval_irq [*8])
        else $error("interval pulse too long");
    a_watch_single_pulse: assert property (o_watch_irq |=> !o_watch_irq [*8])
        else $error("watch pulse too long");
    a_ivl_stopped_quiet: assert property (s_pre_stopped |-> !o_interval_irq)
        else $error("interval pulse while stopped");
    a_watch_pre_quiet: assert property (s_pre_stopped |-> !o_watch_irq)
        else $error("watch pulse with prescaler stopped");
    a_watch_cnt_quiet: assert property (!mode_r[1] [*3] |-> !o_watch_irq)
        else $error("watch pulse with counter stopped");
    a_irq_follows_ivl: assert property (o_interval_irq && mask_r[1] |-> o_irq)
        else $error("unmasked interval event without irq");
    a_irq_all_masked: assert property (mask_r == 2'h0 |-> !o_irq)
        else $error("irq with all events masked");
endmodule

bind wit_timer wit_timer_props u_props (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_req(i_req), .o_rdata(o_rdata), .o_watch_irq(o_watch_irq),
    .o_interval_irq(o_interval_irq), .o_irq(o_irq));

// *** dv/test_wit_timer.sv ***
// Self-checking bench for the watch interval timer
`timescale 1ns/1ns

module test_wit_timer;
    typedef struct packed {logic [7:0] mode; logic watch; logic [31:0] gap;} wit_row_t;
    // Mode, which pulse to time, cycles between pulses at 128 clocks a tick, 2048 with mode bit 7 set
    localparam wit_row_t ROWS [4] = '{'{8'h01, 1'b0, 32'h800}, '{8'h11, 1'b0, 32'h1000},
        '{8'h0b, 1'b1, 32'h1000}, '{8'h81, 1'b0, 32'h8000}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wit_pkg::wit_bus_req_t req = '0;
    logic [7:0] rdata;
    logic watch;
    logic ivl;
    logic irq;
    logic [31:0] n;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    int w_cnt = 0;
    int i_cnt = 0;

    wit_timer dut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_req(req), .o_rdata(rdata),
        .o_watch_irq(watch), .o_interval_irq(ivl), .o_irq(irq));

    // ==========================================================
    // Clock, timeout and helpers
    // ==========================================================
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 99000)
        begin
            failures++;
            finish_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Kind 0 byte write, 1 read, 2 bit write with value in d[7], index in d[2:0]
    task automatic op(input int k, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{a, d, k == 0, k == 1, k == 2, d[2:0], d[7]};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        op(1, a, 8'h00);
        @(negedge clk);
        check(rdata, e);
    endtask
    task automatic gap(input logic w, output logic [31:0] c);
        c = 0;
        while ((w ? watch : ivl) !== 1'b1) @(negedge clk);
        do
        begin
            @(negedge clk);
            c++;
        end
        while ((w ? watch : ivl) !== 1'b1);
    endtask
    task automatic finish_test();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // Sequence
    // ==========================================================
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // Prescaler cleared only once per row, never while a gap is timed
        foreach (ROWS[r])
        begin
            op(0, wit_pkg::MODE_ADDR, 8'h00);
            op(0, wit_pkg::MODE_ADDR, ROWS[r].mode);
            gap(ROWS[r].watch, n);
            check(n, ROWS[r].gap);
        end
        // Second reset in mid-run, with the timer busy
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        rd(wit_pkg::MODE_ADDR, 8'h00);
        rd(wit_pkg::STAT_ADDR, 8'h00);
        rd(wit_pkg::MASK_ADDR, 8'h00);
        rd(16'hff42, 8'h00);
        op(0, wit_pkg::MODE_ADDR, 8'hff);
        rd(wit_pkg::MODE_ADDR, 8'hfb);
        op(2, wit_pkg::MODE_ADDR, 8'h82);
        op(2, wit_pkg::MODE_ADDR, 8'h07);
        rd(wit_pkg::MODE_ADDR, 8'h7b);
        // Prescaler alone running: interval fires, watch must stay silent
        op(0, wit_pkg::MODE_ADDR, 8'h00);
        op(0, wit_pkg::MASK_ADDR, 8'h03);
        op(0, wit_pkg::STAT_ADDR, 8'h03);
        op(0, wit_pkg::MODE_ADDR, 8'h09);
        repeat (4200)
        begin
            @(negedge clk);
            w_cnt += int'(watch === 1'b1);
            i_cnt += int'(ivl === 1'b1);
        end
        check(w_cnt, 0);
        check(i_cnt != 0, 1);
        check(irq, 1'b1);
        op(0, wit_pkg::MODE_ADDR, 8'h00);
        rd(wit_pkg::STAT_ADDR, 8'h02);
        op(0, wit_pkg::MASK_ADDR, 8'h00);
        @(negedge clk);
        check(irq, 1'b0);
        op(0, wit_pkg::STAT_ADDR, 8'h02);
        rd(wit_pkg::STAT_ADDR, 8'h00);
        finish_test();
    end
endmodule
